/* File: design/prs_params.svh */
// Timing counts and widths for the power-on reset and time-reference block
// Assumes ref_clk is the primary system clock at 10 MHz
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_CLK_PERIOD_NS 100
`define PRS_PLL_LOCK_US 100
`define PRS_PLL_LOCK_CYC ((`PRS_PLL_LOCK_US * 1000) / `PRS_CLK_PERIOD_NS)
`define PRS_HRST_MIN_CYC 32
`define PRS_ECHO_CYC 3
`define PRS_STRAP_W 8
`define PRS_TB_W 32
`define PRS_CNT_W 12
`endif

/* File: design/prs_pkg.sv */
// Types for the power-on reset and time-reference block
// Shared by the sequencer and its synchroniser
`include "prs_params.svh"
package prs_pkg;
	typedef enum logic [1:0] {
		PRS_POR  = 2'b00,
		PRS_LOCK = 2'b01,
		PRS_RUN  = 2'b11,
		PRS_EXT  = 2'b10
	} prs_state_t;

	typedef struct packed {
		logic porSync;
		logic hrstSync;
		logic rtcSync;
	} prs_pins_t;

	typedef struct packed {
		prs_state_t                state;
		logic [`PRS_CNT_W-1:0]     count;
		logic [`PRS_STRAP_W-1:0]   straps;
		logic                      porPrev;
		logic                      rtcPrev;
		logic [`PRS_TB_W-1:0]      timeBase;
		logic                      hrstDrive;
	} prs_regs_t;
endpackage

/* File: design/prs_sequencer.sv */
// Power-on reset sequencer: hard reset drive, strap capture, time reference
// Assumes ref_clk is the primary system clock; pins are asynchronous
`timescale 1ns/1ps
module prs_sequencer
	import prs_pkg::*;
#(
	parameter int LOCK_CYC = `PRS_PLL_LOCK_CYC
)(
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     power_on_reset_in,
	input  wire logic                     hard_reset_line_in,
	output logic                          hard_reset_line_out,
	output logic                          hard_reset_line_oe,
	input  wire logic [`PRS_STRAP_W-1:0]  strapIn,
	input  wire logic                     timeRefIn,
	output logic      [`PRS_STRAP_W-1:0]  strapValue,
	output logic                          interruptCounterTick,
	output logic      [`PRS_TB_W-1:0]     timeBaseValue,
	output logic                          timeRefSampled,
	output logic                          coreResetActive
);
	localparam logic [`PRS_CNT_W-1:0] LockLast = `PRS_CNT_W'(LOCK_CYC - 1);
	localparam logic [`PRS_CNT_W-1:0] HrstLast = `PRS_CNT_W'(`PRS_HRST_MIN_CYC - 1);
	localparam logic [`PRS_CNT_W-1:0] EchoLast = `PRS_CNT_W'(`PRS_ECHO_CYC - 1);

	prs_pins_t pins;
	prs_regs_t cur_reg;
	prs_regs_t cur_next;
	logic      risingRef;
	logic      porFall;
	logic [`PRS_STRAP_W-1:0] strapSync;

	// Reset, hard reset and time reference pins, two flops each
	prs_sync #(.WIDTH(3)) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn ({power_on_reset_in, hard_reset_line_in, timeRefIn}),
		.syncOut (pins)
	);

	// Straps take the same two flops, so capture lines up with negation
	prs_sync #(.WIDTH(`PRS_STRAP_W)) u_strap_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn (strapIn),
		.syncOut (strapSync)
	);

	assign risingRef = pins.rtcSync & ~cur_reg.rtcPrev;
	assign porFall   = cur_reg.porPrev & ~pins.porSync;

	always_comb
	begin
		cur_next         = cur_reg;
		cur_next.porPrev = pins.porSync;
		cur_next.rtcPrev = pins.rtcSync;
		// time base counts sampled edges only
		if (risingRef)
		begin
			cur_next.timeBase = cur_reg.timeBase + `PRS_TB_W'(1);
		end
		if (pins.porSync)
		begin
			// drive hard reset during power-on reset
			cur_next.state     = PRS_POR;
			cur_next.hrstDrive = 1'b1;
			cur_next.count     = '0;
			cur_next.timeBase  = '0;
		end
		else
		begin
			unique case (cur_reg.state)
				PRS_POR:
				begin
					if (porFall)
					begin
						cur_next.straps = strapSync;
						cur_next.state  = PRS_LOCK;
						cur_next.count  = '0;
					end
				end
				PRS_LOCK:
				begin
					// hold drive for PLL lock time
					if (cur_reg.count == LockLast)
					begin
						cur_next.state     = PRS_RUN;
						cur_next.hrstDrive = 1'b0;
						cur_next.count     = '0;
					end
					else
					begin
						cur_next.count = cur_reg.count + `PRS_CNT_W'(1);
					end
				end
				PRS_RUN:
				begin
					// external hard reset seen as input
					// Own drive still echoes through the synchroniser: blank it
					if (cur_reg.count < EchoLast)
					begin
						cur_next.count = cur_reg.count + `PRS_CNT_W'(1);
					end
					else if (pins.hrstSync)
					begin
						cur_next.state = PRS_EXT;
						cur_next.count = '0;
					end
				end
				PRS_EXT:
				begin
					if (!pins.hrstSync)
					begin
						cur_next.state = PRS_RUN;
						cur_next.count = EchoLast;
					end
					else if (cur_reg.count != HrstLast)
					begin
						cur_next.count = cur_reg.count + `PRS_CNT_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cur_reg.state    <= PRS_POR;
			cur_reg.count    <= '0;
			cur_reg.straps   <= '0;
			cur_reg.porPrev  <= 1'b0;
			cur_reg.rtcPrev  <= 1'b0;
			cur_reg.timeBase <= '0;
			cur_reg.hrstDrive <= 1'b1;
		end
		else
		begin
			cur_reg <= cur_next;
		end
	end

	assign hard_reset_line_out  = 1'b1;
	assign hard_reset_line_oe   = cur_reg.hrstDrive;
	assign strapValue           = cur_reg.straps;
	assign timeBaseValue        = cur_reg.timeBase;
	assign timeRefSampled       = cur_reg.rtcPrev;
	assign interruptCounterTick = risingRef;
	assign coreResetActive      = cur_reg.hrstDrive | (cur_reg.state == PRS_EXT);

	a_por_drives_hrst: assert property (@(posedge ref_clk) disable iff (rst)
		pins.porSync |=> hard_reset_line_oe)
		else $error("hard reset not driven during power-on reset");

	a_release_after_por: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(hard_reset_line_oe) |-> !pins.porSync && $past(cur_reg.state) == PRS_LOCK)
		else $error("hard reset released before power-on reset negated");

	a_lock_wait_len: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(hard_reset_line_oe) |-> $past(cur_reg.count) == LockLast)
		else $error("hard reset released before lock time");

	a_strap_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(porFall && cur_reg.state == PRS_POR) |=> strapValue == $past(strapSync))
		else $error("straps not captured at negation");

	a_strap_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.state == PRS_RUN && !pins.porSync) |=> $stable(strapValue))
		else $error("straps changed after capture");

	a_tb_tick: assert property (@(posedge ref_clk) disable iff (rst)
		(risingRef && !pins.porSync) |=> timeBaseValue == $past(timeBaseValue) + 1)
		else $error("time base missed reference edge");

	a_tb_idle: assert property (@(posedge ref_clk) disable iff (rst)
		(!risingRef && !pins.porSync) |=> $stable(timeBaseValue))
		else $error("time base moved without reference edge");

	a_tick_single: assert property (@(posedge ref_clk) disable iff (rst)
		interruptCounterTick |=> !interruptCounterTick && timeRefSampled)
		else $error("counter tick longer than one cycle");

	a_por_clears_tb: assert property (@(posedge ref_clk) disable iff (rst)
		pins.porSync |=> timeBaseValue == '0)
		else $error("time base not cleared during power-on reset");

	a_echo_blank: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(hard_reset_line_oe) |-> !coreResetActive [*3])
		else $error("own hard reset drive seen as external reset");

	a_ext_entry: assert property (@(posedge ref_clk) disable iff (rst)
		(cur_reg.state == PRS_RUN && cur_reg.count == EchoLast && pins.hrstSync)
		|=> coreResetActive)
		else $error("external hard reset not seen");

	c_por_release: cover property (@(posedge ref_clk) disable iff (rst)
		$fell(hard_reset_line_oe));
	c_ext_hrst: cover property (@(posedge ref_clk) disable iff (rst)
		cur_reg.state == PRS_EXT);
	c_ref_tick: cover property (@(posedge ref_clk) disable iff (rst)
		interruptCounterTick);
	c_strap_take: cover property (@(posedge ref_clk) disable iff (rst)
		porFall && cur_reg.state == PRS_POR);
endmodule

/* File: design/prs_sync.sv */
// Two-flop synchroniser bank for asynchronous pins
// Assumes inputs come from outside the ref_clk domain
`timescale 1ns/1ps
module prs_sync
	import prs_pkg::*;
#(
	parameter int WIDTH = 3
)(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end
		else
		begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule

/* File: test/prs_bench.sv */
// Bench for the power-on reset sequencer with a board model
// Assumes ref_clk of 100 ns and a shortened lock count
`include "prs_params.svh"
`timescale 1ns/1ps
module prs_bench;
	import prs_pkg::*;
	localparam int LOCK = 8;
	logic ref_clk, rst, extDrv, oe, hOut, tick, refS, coreRst;
	logic [7:0]  straps;
	logic [31:0] tb;
	wire  [7:0]  strapPin;
	wire         por, refPin, hrLine;
	int          errorCnt, checked, ticks, base;
	// Wired level of the hard reset line, low when nobody drives
	assign hrLine = (oe & hOut) | extDrv;
	prs_board u_prs_board (.ref_clk(ref_clk), .porPin(por), .strapPin(strapPin), .refPin(refPin));
	prs_sequencer #(.LOCK_CYC(LOCK)) u_prs_sequencer (.ref_clk(ref_clk), .rst(rst),
		.power_on_reset_in(por), .hard_reset_line_in(hrLine), .hard_reset_line_out(hOut),
		.hard_reset_line_oe(oe), .strapIn(strapPin), .timeRefIn(refPin), .strapValue(straps),
		.interruptCounterTick(tick), .timeBaseValue(tb), .timeRefSampled(refS),
		.coreResetActive(coreRst));
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (tick === 1'b1)
			ticks++;
	task automatic results();
		$display("compares %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic test_por(input logic [7:0] v);
		int i;
		fork
			u_prs_board.por(v);
			begin
				cyc(4);
				chk("oe", 1, oe);
				chk("out", 1, hOut);
				chk("timebase", 0, tb);
			end
		join
		cyc(LOCK);
		chk("oe held", 1, oe);
		for (i = 0; i < 20 && oe !== 1'b0; i++)
			cyc(1);
		chk("oe release", 0, oe);
		chk("straps", v, straps);
		cyc(2);
		chk("core", 0, coreRst);
		$display("test_por done");
	endtask
	task automatic test_ref();
		base = tb;
		ticks = 0;
		u_prs_board.pulses(5);
		cyc(4);
		chk("timebase", base + 5, tb);
		chk("ticks", 5, ticks);
		cyc(60);
		chk("idle base", base + 5, tb);
		chk("idle level", 0, refS);
		$display("test_ref done");
	endtask
	task automatic test_ext();
		extDrv = 1'b1;
		cyc(4);
		chk("core on", 1, coreRst);
		cyc(28);
		extDrv = 1'b0;
		cyc(4);
		chk("core off", 0, coreRst);
		chk("oe", 0, oe);
		$display("test_ext done");
	endtask
	initial
	begin
		errorCnt = 0;
		checked = 0;
		extDrv = 1'b0;
		rst = 1'b1;
		cyc(20);
		rst = 1'b0;
		test_por(8'ha5);
		test_ref();
		test_ext();
		test_por(8'h5a);
		test_ref();
		results();
	end
endmodule

/* File: test/prs_board.sv */
// Board model: reset supervisor, strap drivers and slow time reference
// Assumes the bench calls its tasks just after a rising edge of ref_clk
`include "prs_params.svh"
`timescale 1ns/1ps
module prs_board
	import prs_pkg::*;
(
	input  wire logic                    ref_clk,
	output logic                         porPin,
	output logic [`PRS_STRAP_W-1:0]      strapPin,
	output logic                         refPin
);
	initial
	begin
		porPin = 1'b1;
		strapPin = 8'h00;
		refPin = 1'b0;
	end
	task automatic por(input logic [`PRS_STRAP_W-1:0] v);
		porPin = 1'b1;
		// straps settled long before a 1 ms release
		strapPin = v;
		repeat (10000) @(posedge ref_clk);
		#1 porPin = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 strapPin = ~v;
	endtask
	task automatic pulses(input int n);
		// eight cycles high and eight low
		repeat (n)
		begin
			refPin = 1'b1;
			repeat (8) @(posedge ref_clk);
			#1 refPin = 1'b0;
			repeat (8) @(posedge ref_clk);
			#1;
		end
	endtask
endmodule
